// ===== rtl/eq_adapt_pkg.sv
// Package: register map, field positions, reset values and shared types
// for the per-channel equalizer adaptation and override control block.
// Assumes one core clock and a byte-wide register port from the SMBus engine.
package eq_adapt_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CDR_RESET     = 8'h0a;
  localparam logic [7:0] ADDR_TAP_SIGN      = 8'h11;
  localparam logic [7:0] ADDR_FIRST_TAP     = 8'h12;
  localparam logic [7:0] ADDR_MANUAL_APPLY  = 8'h15;
  localparam logic [7:0] ADDR_DRV_SLEW      = 8'h18;
  localparam logic [7:0] ADDR_EQ_POWER      = 8'h1e;
  localparam logic [7:0] ADDR_OUT_INVERT    = 8'h1f;
  localparam logic [7:0] ADDR_TAPS_2_3      = 8'h20;
  localparam logic [7:0] ADDR_TAPS_4_5      = 8'h21;
  localparam logic [7:0] ADDR_TAP_OVERRIDE  = 8'h23;
  localparam logic [7:0] ADDR_MERIT_FB      = 8'h2c;
  localparam logic [7:0] ADDR_CTLE_START    = 8'h2f;
  localparam logic [7:0] ADDR_ADAPT_MODE    = 8'h31;
  localparam logic [7:0] ADDR_FACTOR_A      = 8'h6b;
  localparam logic [7:0] ADDR_FACTOR_B      = 8'h6c;
  localparam logic [7:0] ADDR_FACTOR_C      = 8'h6d;
  localparam logic [7:0] ADDR_MERIT_EN      = 8'h6e;
  localparam logic [7:0] ADDR_OBS_FIRST     = 8'h71;
  localparam logic [7:0] ADDR_OBS_LAST      = 8'h75;
  localparam logic [7:0] ADDR_CHAN_SEL      = 8'hff;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_CDR_RST_LO      = 2;
  localparam int BIT_CDR_RST_HI      = 3;
  localparam int BIT_FIRST_SIGN      = 7;
  localparam int BIT_MANUAL_APPLY    = 7;
  localparam int BIT_SLOW_SLEW       = 2;
  localparam int BIT_FB_POWERDOWN    = 3;
  localparam int BIT_OUT_INVERT      = 7;
  localparam int BIT_OVERRIDE_EN     = 6;
  localparam int BIT_MERIT_FB_LO     = 4;
  localparam int BIT_CTLE_START      = 0;
  localparam int BIT_MODE_LO         = 5;
  localparam int BIT_MERIT_CTLE_LO   = 3;
  localparam int BIT_CFG_MERIT_CTLE  = 7;
  localparam int BIT_CFG_MERIT_FB    = 6;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_EQ_POWER     = 8'h08;  // Feedback equalizer powered down
  localparam logic [7:0] RST_TAP_OVERRIDE = 8'h40;  // Override enable set
  localparam logic [7:0] RST_MERIT_FB     = 8'h30;  // Both openings
  localparam logic [7:0] RST_ADAPT_MODE   = 8'h38;  // Mode 1, CTLE merit both
  localparam logic [7:0] RST_ZERO         = 8'h00;

  // ----------------------------------------------------------------------
  // Codes and types
  // ----------------------------------------------------------------------
  localparam logic [1:0] MERIT_INVALID = 2'h0;
  localparam logic [1:0] MERIT_HORIZ   = 2'h1;
  localparam logic [1:0] MERIT_VERT    = 2'h2;
  localparam logic [1:0] MERIT_BOTH    = 2'h3;
  localparam logic [1:0] MODE_CTLE_OPT = 2'h2;
  localparam logic [1:0] MODE_CTLE_LCK = 2'h3;
  localparam int         FRAC_BITS     = 8;     // Factor a is a/256

  typedef enum logic [2:0] {
    PH_IDLE, PH_CTLE_FIRST, PH_FEEDBACK, PH_CTLE_AGAIN, PH_CTLE_ONLY, PH_FB_ONLY
  } adapt_phase_e;

  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
  } reg_req_s;

  typedef struct packed {
    logic [4:0] sign;   // Bit n is tap n+1, 1 = positive
    logic [4:0] w1;     // First tap weight
    logic [3:0] w2;
    logic [3:0] w3;
    logic [3:0] w4;
    logic [3:0] w5;
  } tap_set_s;

endpackage

// ===== rtl/equalizer_adapt_override_ctrl.sv
// Per-channel equalizer adaptation and override control: register bank,
// tap override path, adaptation start logic, sequencer and merit datapath.
// Assumes a byte register port from the SMBus engine on the core clock;
// signal detect and lock arrive from analog and are synchronised here.
//
// Notes on behaviour
// RULE_01 - Tap override enable must be set before manual taps; resets to one.
// RULE_02 - Taps reach signal path only while feedback powerdown bit is zero.
// RULE_03 - Manual tap weights apply only with manual-apply bit set; resets clear.
// RULE_04 - First tap weight is five bits held in bits 4:0.
// RULE_05 - First tap sign bit: zero negative, one positive; resets zero.
// RULE_06 - Taps two to five are four-bit weights; signs reset zero.
// RULE_07 - Lock loss after tap change may rerun CTLE adaptation on its own.
// RULE_08 - Adapt mode 2 or 3: every CDR reset starts feedback adaptation.
// RULE_09 - CDR reset by host write or signal appearing while unlocked.
// RULE_10 - Host seeds tap registers from observation registers before adapting.
// RULE_11 - Feedback adaptation keeps starting taps unless merit strictly improves.
// RULE_12 - CTLE adaptation starts on one-then-zero write; keeps start if no gain.
// RULE_13 - Slow slew bit roughly doubles driver edge times; resets zero.
// RULE_14 - Writing one to invert bit inverts this channel's output data.
// RULE_15 - Default merit is minimum of horizontal and scaled vertical opening.
// RULE_16 - Feedback merit type: 0 invalid, 1 horizontal, 2 vertical, 3 both.
// RULE_17 - CTLE merit type uses same encoding in its own field.
// RULE_18 - Configurable merit is (h-b)*a plus (v-c)*(1-a).
// RULE_19 - Separate enables select configurable merit for CTLE and feedback.
// RULE_20 - Channel select register steers which channel later accesses reach.
// RULE_21 - Mode 10: CTLE to optimum, taps, CTLE; 11: first pass to lock.
// RULE_22 - Merit arithmetic is signed and wide; factor a unsigned fraction.
// RULE_23 - Config registers read back stored values; observation reads live state.
`timescale 1ns/1ps

module equalizer_adapt_override_ctrl
  import eq_adapt_pkg::*;
#(
  parameter int         EYE_W      = 8,      // Eye opening measurement width
  parameter logic [7:0] CHAN_BIT   = 8'h01,  // This channel's bit in channel select
  parameter int         VSCALE_NUM = 64      // Vertical scale, numerator over 64
) (
  input  wire logic                     I_REF_CLK,        // Core clock, 40 MHz
  input  wire logic                     I_RESET,          // Async reset, active high
  input  wire eq_adapt_pkg::reg_req_s   I_REG_REQ,        // Register request
  output logic [7:0]                    O_REG_RDATA,      // Read data
  output logic                          O_REG_RVALID,     // Read data valid pulse
  input  wire logic                     I_SIGNAL_DETECT,  // Async signal present
  input  wire logic                     I_CDR_LOCKED,     // Async lock indication
  input  wire eq_adapt_pkg::tap_set_s   I_ADAPTED_TAPS,   // Live adapted taps
  input  wire logic                     I_TRIAL_VALID,    // Eye result pulse
  input  wire logic [EYE_W-1:0]         I_HORIZ_EYE,      // Horizontal eye opening
  input  wire logic [EYE_W-1:0]         I_VERT_EYE,       // Vertical eye opening
  input  wire logic                     I_STAGE_DONE,     // Current pass finished
  output eq_adapt_pkg::tap_set_s        O_TAPS,           // Taps to signal path
  output logic                          O_FB_POWERDOWN,   // Feedback eq powered down
  output logic                          O_TAP_OVERRIDE,   // Override enable level
  output logic                          O_SLOW_SLEW,      // Driver slow edges
  output logic                          O_OUT_INVERT,     // Output data inverted
  output logic                          O_CDR_RESET,      // CDR reset pulse
  output logic                          O_CTLE_LOCK_ONLY, // First CTLE pass to lock
  output eq_adapt_pkg::adapt_phase_e    O_PHASE,          // Adaptation pass
  output logic signed [EYE_W+10:0]      O_MERIT,          // Current trial merit
  output logic                          O_TRIAL_BETTER    // Trial beats best pulse
);
  import eq_adapt_pkg::*;

  localparam int MW = EYE_W + 11;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] sd_sync_r;
  logic [1:0] lk_sync_r;
  logic       sd_prev_r;
  logic       lk_prev_r;

  // Two stages for each analog level
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      sd_sync_r <= 2'h0;
      lk_sync_r <= 2'h0;
      sd_prev_r <= 1'b0;
      lk_prev_r <= 1'b0;
    end else begin
      sd_sync_r <= {sd_sync_r[0], I_SIGNAL_DETECT};
      lk_sync_r <= {lk_sync_r[0], I_CDR_LOCKED};
      sd_prev_r <= sd_sync_r[1];
      lk_prev_r <= lk_sync_r[1];
    end
  end

  logic sig_rise;
  logic lock_fall;
  assign sig_rise  = sd_sync_r[1] & ~sd_prev_r;
  assign lock_fall = lk_prev_r & ~lk_sync_r[1];

  // ----------------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------------
  logic [7:0] chan_sel_r;
  logic [7:0] cdr_rst_r, tap_sign_r, first_tap_r, apply_r, slew_r, power_r;
  logic [7:0] invert_r, taps23_r, taps45_r, override_r, merit_fb_r;
  logic [7:0] ctle_start_r, mode_r, fa_r, fb_r, fc_r, merit_en_r;
  logic       sel;
  logic       wr;

  assign sel = |(chan_sel_r & CHAN_BIT);  // [RULE_20]
  assign wr  = I_REG_REQ.wr & sel;

  // Channel select is shared and always writable
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      chan_sel_r <= RST_ZERO;
    end else if (I_REG_REQ.wr && I_REG_REQ.addr == ADDR_CHAN_SEL) begin
      chan_sel_r <= I_REG_REQ.wdata;  // [RULE_20]
    end
  end

  // Channel configuration registers
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cdr_rst_r    <= RST_ZERO;
      tap_sign_r   <= RST_ZERO;          // [RULE_06]
      first_tap_r  <= RST_ZERO;          // [RULE_05]
      apply_r      <= RST_ZERO;          // [RULE_03]
      slew_r       <= RST_ZERO;          // [RULE_13]
      power_r      <= RST_EQ_POWER;      // [RULE_02]
      invert_r     <= RST_ZERO;
      taps23_r     <= RST_ZERO;
      taps45_r     <= RST_ZERO;
      override_r   <= RST_TAP_OVERRIDE;  // [RULE_01]
      merit_fb_r   <= RST_MERIT_FB;      // [RULE_16]
      ctle_start_r <= RST_ZERO;
      mode_r       <= RST_ADAPT_MODE;    // [RULE_17]
      fa_r         <= RST_ZERO;
      fb_r         <= RST_ZERO;
      fc_r         <= RST_ZERO;
      merit_en_r   <= RST_ZERO;
    end else if (wr) begin
      case (I_REG_REQ.addr)
        ADDR_CDR_RESET:    cdr_rst_r    <= I_REG_REQ.wdata;
        ADDR_TAP_SIGN:     tap_sign_r   <= I_REG_REQ.wdata;
        ADDR_FIRST_TAP:    first_tap_r  <= I_REG_REQ.wdata;
        ADDR_MANUAL_APPLY: apply_r      <= I_REG_REQ.wdata;
        ADDR_DRV_SLEW:     slew_r       <= I_REG_REQ.wdata;
        ADDR_EQ_POWER:     power_r      <= I_REG_REQ.wdata;
        ADDR_OUT_INVERT:   invert_r     <= I_REG_REQ.wdata;
        ADDR_TAPS_2_3:     taps23_r     <= I_REG_REQ.wdata;
        ADDR_TAPS_4_5:     taps45_r     <= I_REG_REQ.wdata;
        ADDR_TAP_OVERRIDE: override_r   <= I_REG_REQ.wdata;
        ADDR_MERIT_FB:     merit_fb_r   <= I_REG_REQ.wdata;
        ADDR_CTLE_START:   ctle_start_r <= I_REG_REQ.wdata;
        ADDR_ADAPT_MODE:   mode_r       <= I_REG_REQ.wdata;
        ADDR_FACTOR_A:     fa_r         <= I_REG_REQ.wdata;
        ADDR_FACTOR_B:     fb_r         <= I_REG_REQ.wdata;
        ADDR_FACTOR_C:     fc_r         <= I_REG_REQ.wdata;
        ADDR_MERIT_EN:     merit_en_r   <= I_REG_REQ.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------------
  logic [7:0] obs_byte [5];

  // Observation bytes: sign in bit 7, weight in the low bits
  always_comb begin
    obs_byte[0] = {I_ADAPTED_TAPS.sign[0], 2'h0, I_ADAPTED_TAPS.w1};
    obs_byte[1] = {I_ADAPTED_TAPS.sign[1], 3'h0, I_ADAPTED_TAPS.w2};
    obs_byte[2] = {I_ADAPTED_TAPS.sign[2], 3'h0, I_ADAPTED_TAPS.w3};
    obs_byte[3] = {I_ADAPTED_TAPS.sign[3], 3'h0, I_ADAPTED_TAPS.w4};
    obs_byte[4] = {I_ADAPTED_TAPS.sign[4], 3'h0, I_ADAPTED_TAPS.w5};
  end

  logic [7:0] rd_nxt;

  // Stored values back, live taps from observation, zero elsewhere
  always_comb begin
    rd_nxt = 8'h00;
    case (I_REG_REQ.addr)
      ADDR_CHAN_SEL:     rd_nxt = chan_sel_r;
      ADDR_CDR_RESET:    rd_nxt = cdr_rst_r;
      ADDR_TAP_SIGN:     rd_nxt = tap_sign_r;
      ADDR_FIRST_TAP:    rd_nxt = first_tap_r;
      ADDR_MANUAL_APPLY: rd_nxt = apply_r;
      ADDR_DRV_SLEW:     rd_nxt = slew_r;
      ADDR_EQ_POWER:     rd_nxt = power_r;
      ADDR_OUT_INVERT:   rd_nxt = invert_r;
      ADDR_TAPS_2_3:     rd_nxt = taps23_r;
      ADDR_TAPS_4_5:     rd_nxt = taps45_r;
      ADDR_TAP_OVERRIDE: rd_nxt = override_r;
      ADDR_MERIT_FB:     rd_nxt = merit_fb_r;
      ADDR_CTLE_START:   rd_nxt = ctle_start_r;
      ADDR_ADAPT_MODE:   rd_nxt = mode_r;
      ADDR_FACTOR_A:     rd_nxt = fa_r;
      ADDR_FACTOR_B:     rd_nxt = fb_r;
      ADDR_FACTOR_C:     rd_nxt = fc_r;
      ADDR_MERIT_EN:     rd_nxt = merit_en_r;
      default: begin
        if (I_REG_REQ.addr >= ADDR_OBS_FIRST && I_REG_REQ.addr <= ADDR_OBS_LAST) begin
          rd_nxt = obs_byte[3'(I_REG_REQ.addr - ADDR_OBS_FIRST)];  // [RULE_23] [RULE_10]
        end
      end
    endcase
    if (!sel && I_REG_REQ.addr != ADDR_CHAN_SEL) begin
      rd_nxt = 8'h00;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_REG_RDATA  <= 8'h00;
      O_REG_RVALID <= 1'b0;
    end else begin
      O_REG_RVALID <= I_REG_REQ.rd;
      if (I_REG_REQ.rd) begin
        O_REG_RDATA <= rd_nxt;  // [RULE_23]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Tap path and driver controls
  // ----------------------------------------------------------------------
  tap_set_s manual_taps;
  logic     use_manual;

  assign manual_taps = '{sign: {tap_sign_r[3:0], first_tap_r[BIT_FIRST_SIGN]},  // [RULE_05]
                         w1:   first_tap_r[4:0],                                 // [RULE_04]
                         w2:   taps23_r[3:0], w3: taps23_r[7:4],                 // [RULE_06]
                         w4:   taps45_r[3:0], w5: taps45_r[7:4]};
  assign use_manual  = override_r[BIT_OVERRIDE_EN] & apply_r[BIT_MANUAL_APPLY];  // [RULE_01] [RULE_03]

  // Taps reach the path only with the feedback equalizer powered
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_TAPS         <= '0;
      O_FB_POWERDOWN <= 1'b1;
      O_TAP_OVERRIDE <= 1'b1;
    end else begin
      O_FB_POWERDOWN <= power_r[BIT_FB_POWERDOWN];
      O_TAP_OVERRIDE <= override_r[BIT_OVERRIDE_EN];
      if (power_r[BIT_FB_POWERDOWN]) begin
        O_TAPS <= '0;                          // [RULE_02]
      end else if (use_manual) begin
        O_TAPS <= manual_taps;                 // [RULE_03]
      end else begin
        O_TAPS <= I_ADAPTED_TAPS;
      end
    end
  end

  // Output driver bits
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_SLOW_SLEW  <= 1'b0;
      O_OUT_INVERT <= 1'b0;
    end else begin
      O_SLOW_SLEW  <= slew_r[BIT_SLOW_SLEW];   // [RULE_13]
      O_OUT_INVERT <= invert_r[BIT_OUT_INVERT]; // [RULE_14]
    end
  end

  // ----------------------------------------------------------------------
  // Adaptation start events
  // ----------------------------------------------------------------------
  logic       host_cdr_rst;
  logic       cdr_rst_evt;
  logic       ctle_host_start;
  logic       tap_write;
  logic       tap_changed_r;
  logic [1:0] adapt_mode;

  assign adapt_mode      = mode_r[BIT_MODE_LO +: 2];
  assign host_cdr_rst    = wr && I_REG_REQ.addr == ADDR_CDR_RESET
                           && |I_REG_REQ.wdata[BIT_CDR_RST_HI:BIT_CDR_RST_LO];
  assign cdr_rst_evt     = host_cdr_rst | (sig_rise & ~lk_sync_r[1]);  // [RULE_09]
  assign ctle_host_start = wr && I_REG_REQ.addr == ADDR_CTLE_START
                           && ctle_start_r[BIT_CTLE_START]
                           && !I_REG_REQ.wdata[BIT_CTLE_START];       // [RULE_12]
  assign tap_write       = wr && (I_REG_REQ.addr == ADDR_TAP_SIGN
                           || I_REG_REQ.addr == ADDR_FIRST_TAP
                           || I_REG_REQ.addr == ADDR_TAPS_2_3
                           || I_REG_REQ.addr == ADDR_TAPS_4_5);

  // Remember a tap change until lock is lost or a CDR reset event occurs
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      tap_changed_r <= 1'b0;
    end else if (tap_write) begin
      tap_changed_r <= 1'b1;
    end else if (lock_fall || cdr_rst_evt) begin
      tap_changed_r <= 1'b0;
    end
  end

  // CDR reset pulse out
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_CDR_RESET <= 1'b0;
    end else begin
      O_CDR_RESET <= cdr_rst_evt;  // [RULE_09]
    end
  end

  // ----------------------------------------------------------------------
  // Adaptation sequencer
  // ----------------------------------------------------------------------
  adapt_phase_e phase_r;
  logic         lock_only_r;
  logic         full_mode;

  assign full_mode = adapt_mode == MODE_CTLE_OPT || adapt_mode == MODE_CTLE_LCK;

  // Passes: CTLE, taps, CTLE again in modes 2 and 3
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      phase_r     <= PH_IDLE;
      lock_only_r <= 1'b0;
    end else if (cdr_rst_evt && full_mode) begin
      phase_r     <= PH_CTLE_FIRST;                       // [RULE_08] [RULE_21]
      lock_only_r <= adapt_mode == MODE_CTLE_LCK;         // [RULE_21]
    end else if (ctle_host_start) begin
      phase_r     <= PH_CTLE_ONLY;                        // [RULE_12]
      lock_only_r <= 1'b0;
    end else if (lock_fall && tap_changed_r) begin
      phase_r     <= PH_CTLE_ONLY;                        // [RULE_07]
      lock_only_r <= 1'b1;
    end else if (I_STAGE_DONE) begin
      lock_only_r <= 1'b0;
      case (phase_r)
        PH_CTLE_FIRST: phase_r <= PH_FEEDBACK;
        PH_FEEDBACK:   phase_r <= PH_CTLE_AGAIN;          // [RULE_21]
        PH_CTLE_AGAIN: phase_r <= PH_IDLE;
        PH_CTLE_ONLY:  phase_r <= PH_IDLE;
        PH_FB_ONLY:    phase_r <= PH_IDLE;
        default:       phase_r <= PH_IDLE;
      endcase
    end
  end

  // Phase outputs
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_PHASE          <= PH_IDLE;
      O_CTLE_LOCK_ONLY <= 1'b0;
    end else begin
      O_PHASE          <= phase_r;
      O_CTLE_LOCK_ONLY <= lock_only_r;
    end
  end

  // ----------------------------------------------------------------------
  // Figure of merit datapath
  // ----------------------------------------------------------------------
  logic                 fb_pass;
  logic [1:0]           mtype;
  logic                 cfg_en;
  logic signed [MW-1:0] h_s, v_s, v_scaled, dflt, cfg, merit_nxt;

  assign fb_pass  = phase_r == PH_FEEDBACK || phase_r == PH_FB_ONLY;
  assign mtype    = fb_pass ? merit_fb_r[BIT_MERIT_FB_LO +: 2]
                            : mode_r[BIT_MERIT_CTLE_LO +: 2];        // [RULE_16] [RULE_17]
  assign cfg_en   = fb_pass ? merit_en_r[BIT_CFG_MERIT_FB]
                            : merit_en_r[BIT_CFG_MERIT_CTLE];        // [RULE_19]
  assign h_s      = MW'(I_HORIZ_EYE);
  assign v_s      = MW'(I_VERT_EYE);
  assign v_scaled = MW'((v_s * MW'(VSCALE_NUM)) >>> 6);              // [RULE_15]
  assign dflt     = (h_s < v_scaled) ? h_s : v_scaled;               // [RULE_15]
  // Signed products with a as unsigned a/256
  assign cfg      = MW'(((h_s - $signed(MW'(fb_r))) * $signed(MW'(fa_r))
                      + (v_s - $signed(MW'(fc_r)))
                      * (MW'(1 << FRAC_BITS) - $signed(MW'(fa_r))))
                      >>> FRAC_BITS);                                // [RULE_18] [RULE_22]

  // Configurable merit when enabled, else select by type; invalid code yields zero
  always_comb begin
    merit_nxt = '0;
    if (cfg_en) begin
      merit_nxt = cfg;
    end else begin
      case (mtype)
        MERIT_HORIZ: merit_nxt = h_s;
        MERIT_VERT:  merit_nxt = v_scaled;
        MERIT_BOTH:  merit_nxt = dflt;
        default:     merit_nxt = '0;                                  // [RULE_16]
      endcase
    end
  end

  logic signed [MW-1:0] best_r;
  logic                 have_best_r;
  logic                 better;

  assign better = I_TRIAL_VALID && phase_r != PH_IDLE
                  && (!have_best_r || merit_nxt > best_r);            // [RULE_11]

  // First trial of a pass is the starting setting, except a lock-loss rerun begun during another pass; only strict gains win
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      best_r      <= '0;
      have_best_r <= 1'b0;
    end else if (cdr_rst_evt || ctle_host_start || I_STAGE_DONE) begin
      have_best_r <= 1'b0;                                            // [RULE_12]
    end else if (better) begin
      best_r      <= merit_nxt;
      have_best_r <= 1'b1;
    end
  end

  // Merit outputs
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_MERIT        <= '0;
      O_TRIAL_BETTER <= 1'b0;
    end else begin
      if (I_TRIAL_VALID) begin
        O_MERIT <= merit_nxt;
      end
      O_TRIAL_BETTER <= better;                                       // [RULE_11]
    end
  end

endmodule // equalizer_adapt_override_ctrl

// ===== dv/eq_host_model.sv
// Host model: byte register cycles toward the control block
`timescale 1ns/1ps
module eq_host_model
  import eq_adapt_pkg::*;
(
  input  wire logic       clk,    // Core clock
  input  wire logic [7:0] rdata,  // Read data
  input  wire logic       rvalid, // Read data valid
  output reg_req_s        req     // Request
);
  initial req = '0;
  // One request over its taking edge, data taken at the edge that sees valid
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk);
    #1 req = '{w, !w, a, d};
    @(posedge clk);
    #1 req = '0;
    @(posedge clk);
    q = rvalid ? rdata : 8'hxx;
  endtask
endmodule // eq_host_model

// ===== dv/eq_adapt_checker.sv
// Checker: port relations of the control block, bound to the top
`timescale 1ns/1ps
module eq_adapt_checker
  import eq_adapt_pkg::*;
(
  input wire logic I_REF_CLK, I_RESET, O_REG_RVALID, O_FB_POWERDOWN,
  input wire logic O_TAP_OVERRIDE, O_SLOW_SLEW, O_OUT_INVERT, O_CDR_RESET,
  input wire reg_req_s I_REG_REQ,
  input wire tap_set_s O_TAPS
);
  logic sel_r;
  // Channel selected for writes
  always_ff @(posedge I_REF_CLK or posedge I_RESET)
    if (I_RESET) sel_r <= 1'b0;
    else if (I_REG_REQ.wr && I_REG_REQ.addr == 8'hff) sel_r <= I_REG_REQ.wdata[0];
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  property p_fld(logic [7:0] a, int b, logic o);
    I_REG_REQ.wr && I_REG_REQ.addr == a && sel_r |=> ##1 o == $past(I_REG_REQ.wdata[b], 2);
  endproperty
  a_override_level: assert property (p_fld(8'h23, 6, O_TAP_OVERRIDE))
    else $error("override level wrong");
  a_powerdown_level: assert property (p_fld(8'h1e, 3, O_FB_POWERDOWN))
    else $error("powerdown level wrong");
  a_slew_level: assert property (p_fld(8'h18, 2, O_SLOW_SLEW))
    else $error("slew level wrong");
  a_invert_level: assert property (p_fld(8'h1f, 7, O_OUT_INVERT))
    else $error("invert level wrong");
  a_read_answer: assert property (I_REG_REQ.rd |=> O_REG_RVALID)
    else $error("read not answered");
  a_rvalid_cause: assert property (O_REG_RVALID |-> $past(I_REG_REQ.rd))
    else $error("stray read valid");
  a_cdr_write: assert property (I_REG_REQ.wr && I_REG_REQ.addr == 8'h0a && sel_r
    && |I_REG_REQ.wdata[3:2] |=> O_CDR_RESET) else $error("no CDR reset");
  a_pd_zero_taps: assert property (O_FB_POWERDOWN && $past(O_FB_POWERDOWN, 2)
    |-> O_TAPS == '0) else $error("taps while powered down");
  c_cdr: cover property (O_CDR_RESET);
  c_read: cover property (O_REG_RVALID);
  c_taps: cover property (!O_FB_POWERDOWN && O_TAPS != '0);
endmodule // eq_adapt_checker
bind equalizer_adapt_override_ctrl eq_adapt_checker i_chk (.*);

// ===== dv/equalizer_adapt_override_ctrl_tb_top.sv
// Testbench: register cycles with expected values
`timescale 1ns/1ps
module equalizer_adapt_override_ctrl_tb_top;
  import eq_adapt_pkg::*;
  logic clk = 0, rst = 1, tv = 0, sdn = 0, sd = 0, lk = 0, pd, ov, sl, inv, lo, rv, bt;
  logic [7:0] q, rdat;
  int fails = 0, n_compared = 0, cyc = 0, nb = 0;
  reg_req_s req;
  tap_set_s taps, at = '{5'h15, 5'h0c, 4'h1, 4'h2, 4'h3, 4'h4};
  adapt_phase_e ph;
  logic signed [18:0] mer;
  logic [7:0] ra[5] = '{8'h1e, 8'h23, 8'h2c, 8'h31, 8'h18};
  logic [7:0] re[5] = '{8'h08, 8'h40, 8'h30, 8'h38, 8'h00};
  adapt_phase_e walk[3] = '{PH_FEEDBACK, PH_CTLE_AGAIN, PH_IDLE};
  initial forever #12.5 clk = ~clk;
  eq_host_model i_host (.clk(clk), .rdata(rdat), .rvalid(rv), .req(req));
  equalizer_adapt_override_ctrl i_dut (.I_REF_CLK(clk), .I_RESET(rst), .I_REG_REQ(req),
    .O_REG_RDATA(rdat), .O_REG_RVALID(rv), .I_SIGNAL_DETECT(sd), .I_CDR_LOCKED(lk),
    .I_ADAPTED_TAPS(at), .I_TRIAL_VALID(tv), .I_HORIZ_EYE(8'h28), .I_VERT_EYE(8'h1e),
    .I_STAGE_DONE(sdn), .O_TAPS(taps), .O_FB_POWERDOWN(pd), .O_TAP_OVERRIDE(ov),
    .O_SLOW_SLEW(sl), .O_OUT_INVERT(inv), .O_CDR_RESET(), .O_CTLE_LOCK_ONLY(lo),
    .O_PHASE(ph), .O_MERIT(mer), .O_TRIAL_BETTER(bt));
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %0h want %0h", $time, g, e);
    end
  endtask
  task automatic w(input logic [7:0] a, d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic r(input logic [7:0] a, e);
    i_host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1;
    @(posedge clk);
    #1 s = 0;
    #100;
  endtask
  task automatic conclude();
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (bt === 1'b1) nb++;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    r(8'h1e, 8'h00);
    w(8'hff, 8'h01);
    foreach (ra[i]) r(ra[i], re[i]);
    chk({pd, ov, sl, inv, taps}, 30'h30000000);
    w(8'h23, 8'h40);
    w(8'h12, 8'h9f);
    w(8'h20, 8'ha5);
    w(8'h21, 8'h3c);
    w(8'h11, 8'hcb);
    w(8'h1e, 8'h00);
    w(8'h15, 8'h80);
    #100 chk(taps, {5'h17, 5'h1f, 4'h5, 4'ha, 4'hc, 4'h3});
    r(8'h11, 8'hcb);
    w(8'h15, 8'h00);
    #100 chk(taps, at);
    w(8'h71, 8'h00);
    r(8'h71, 8'h8c);
    r(8'h75, 8'h84);
    r(8'h40, 8'h00);
    w(8'h15, 8'h80);
    w(8'h1e, 8'h08);
    w(8'h18, 8'h04);
    w(8'h1f, 8'h80);
    #100 chk({taps, sl, inv}, 28'h3);
    for (int m = 1; m < 4; m++) begin
      w(8'h31, 8'(8'h18 | (m << 5)));
      w(8'h0a, 8'h0c);
      #100 chk({ph, lo}, m > 1 ? {PH_CTLE_FIRST, m == 3} : 4'h0);
      if (m > 1) foreach (walk[i]) begin
        pulse(sdn);
        chk(ph, walk[i]);
      end
    end
    @(posedge clk);
    #1 sd = 1;
    #150 chk({ph, lo}, {PH_CTLE_FIRST, 1'b1});
    w(8'h2f, 8'h01);
    w(8'h2f, 8'h00);
    #100 chk(ph, PH_CTLE_ONLY);
    for (int t = 0; t < 4; t++) begin
      w(8'h31, 8'(t << 3));
      pulse(tv);
      chk(mer, t == 0 ? 0 : t == 1 ? 40 : 30);
    end
    w(8'h6b, 8'h80);
    w(8'h6c, 8'h0a);
    w(8'h6d, 8'h05);
    w(8'h6e, 8'h80);
    pulse(tv);
    chk(mer, 27);
    @(posedge clk);
    #1 lk = 1;
    w(8'h12, 8'h9f);
    #1 lk = 0;
    #150 chk({ph, lo}, {PH_CTLE_ONLY, 1'b1});
    chk(nb, 2);
    conclude();
  end
endmodule // equalizer_adapt_override_ctrl_tb_top
